/* src/ebt_pkg.sv */
// Package of constants for the eight-bit timer control and status block
package ebt_pkg;
    // Register offsets (block-local map)
    localparam logic [3:0] EBT_OFF_CTRL_TWO  = 4'h0;
    localparam logic [3:0] EBT_OFF_CTRL_ONE  = 4'h1;
    localparam logic [3:0] EBT_OFF_FLAGS     = 4'h2;
    localparam logic [3:0] EBT_OFF_CAP_ONE   = 4'h3;
    localparam logic [3:0] EBT_OFF_CMP_ONE   = 4'h4;
    localparam logic [3:0] EBT_OFF_COUNT     = 4'h5;
    localparam logic [3:0] EBT_OFF_ALT_COUNT = 4'h6;
    localparam logic [3:0] EBT_OFF_CAP_TWO   = 4'h7;
    localparam logic [3:0] EBT_OFF_CMP_TWO   = 4'h8;
    // Control one fields
    localparam int EBT_C1_CAP_IE  = 7;
    localparam int EBT_C1_CMP_IE  = 6;
    localparam int EBT_C1_OVF_IE  = 5;
    localparam int EBT_C1_FORCE2  = 4;
    localparam int EBT_C1_FORCE1  = 3;
    localparam int EBT_C1_LEVEL2  = 2;
    localparam int EBT_C1_EDGE1   = 1;
    localparam int EBT_C1_LEVEL1  = 0;
    // Control two fields
    localparam int EBT_C2_PIN1_EN = 7;
    localparam int EBT_C2_PIN2_EN = 6;
    localparam int EBT_C2_ONEPULS = 5;
    localparam int EBT_C2_PWM     = 4;
    localparam int EBT_C2_CLK_HI  = 3;
    localparam int EBT_C2_CLK_LO  = 2;
    localparam int EBT_C2_EDGE2   = 1;
    // Flag register fields
    localparam int EBT_F_CAP1     = 7;
    localparam int EBT_F_CMP1     = 6;
    localparam int EBT_F_OVF      = 5;
    localparam int EBT_F_CAP2     = 4;
    localparam int EBT_F_CMP2     = 3;
    localparam int EBT_F_FREEZE   = 2;
    // Reset and reload values
    localparam logic [7:0] EBT_CTRL_RESET  = 8'h00;
    localparam logic [7:0] EBT_COUNT_RESET = 8'hfc;
    localparam logic [7:0] EBT_COUNT_TOP   = 8'hff;
    localparam logic [7:0] EBT_CTRL2_MASK  = 8'hfe;
    // Prescaler divide counts
    localparam int EBT_DIV_BY2    = 2;
    localparam int EBT_DIV_BY4    = 4;
    localparam int EBT_DIV_BY8    = 8;
    localparam int EBT_DIV_SLOW   = 8000;
    localparam logic [1:0] EBT_CLK_DIV4 = 2'b00;
    localparam logic [1:0] EBT_CLK_DIV2 = 2'b01;
    localparam logic [1:0] EBT_CLK_DIV8 = 2'b10;
    localparam logic [1:0] EBT_CLK_SLOW = 2'b11;
endpackage

/* src/ebt_timer.sv */
// Eight-bit timer: control, status, capture, compare and pin logic
//
// Summary of operation
// (R01) All events share one gated interrupt request
// (R02) Capture enable gates both capture flags
// (R03) Compare enable gates both compare flags
// (R04) Overflow enable gates overflow flag
// (R05) Force bit two drives level two out
// (R06) Force bit one drives level one out
// (R07) Level two to pin two, pin one modes
// (R08) Capture one edge bit picks polarity
// (R09) Level one to pin one on match
// (R10) Pin enables only gate the pins
// (R11) One-pulse: capture edge triggers single pulse
// (R12) PWM: compare one length, two period
// (R13) Clock select picks prescaler divide
// (R14) Capture two edge; bit zero reserved
// (R15) Capture flag one set and cleared
// (R16) Compare flag one set and cleared
// (R17) Overflow flag; alternate counter keeps it
// (R18) Capture flag two set and cleared
// (R19) Compare flag two set and cleared
// (R20) Freeze bit stops count, disables outputs
// (R21) No compare flags in PWM mode
// (R22) Capture one register holds counter copy
// (R23) PWM match or pulse trigger reloads FCh
// (R24) Clear needs prior flag read, no newer set
`timescale 1ns/10ps
module ebt_timer
    import ebt_pkg::*;
#(
    parameter int SLOW_DIV = EBT_DIV_SLOW
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // Slow clock tick from oscillator domain, already on this clock
    input  wire logic       osc_tick,
    // CPU side interrupt mask (high means masked)
    input  wire logic       cpu_irq_mask,
    // Capture input pins
    input  wire logic       capture_input_one,
    input  wire logic       capture_input_two,
    // Compare output pins and their alternate-function enables
    output logic            compare_output_one,
    output logic            compare_output_one_en,
    output logic            compare_output_two,
    output logic            compare_output_two_en,
    // Interrupt request and wake from wait
    output logic            timer_irq
);
    import ebt_pkg::*;

    // Slow divider must fit the 14-bit prescaler and count at least two ticks
    if (SLOW_DIV < 2 || SLOW_DIV > 16383) begin : g_bad_slow_div
        $error("SLOW_DIV out of range");
    end

    logic [7:0]  ctrl_one_q, ctrl_two_q, count_q, cap_one_q, cap_two_q;
    logic [7:0]  cmp_one_q, cmp_two_q, cmp_one_act_q, cmp_two_act_q;
    logic        f_cap1_q, f_cmp1_q, f_ovf_q, f_cap2_q, f_cmp2_q, freeze_q;
    logic        arm_cap1_q, arm_cmp1_q, arm_ovf_q, arm_cap2_q, arm_cmp2_q;
    logic [13:0] presc_q;
    logic [1:0]  sync1_q, sync2_q;
    logic        cap1_s_q, cap2_s_q;
    logic        pin1_q, pin2_q;

    // Two flops for each pin, then a history flop for edge detection
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q  <= 2'b00;
            sync2_q  <= 2'b00;
            cap1_s_q <= 1'b0;
            cap2_s_q <= 1'b0;
        end else begin
            sync1_q  <= {sync1_q[0], capture_input_one};
            sync2_q  <= {sync2_q[0], capture_input_two};
            cap1_s_q <= sync1_q[1];
            cap2_s_q <= sync2_q[1];
        end
    end

    // Mode decode; PWM wins over one-pulse when both are set
    logic pwm_mode, one_pulse_mode;
    assign pwm_mode       = ctrl_two_q[EBT_C2_PWM];                          // R12
    assign one_pulse_mode = ctrl_two_q[EBT_C2_ONEPULS] & ~pwm_mode;          // R11

    // Edge select: one picks rising, zero falling
    function automatic logic edge_seen(input logic now, input logic was,
                                       input logic rising);
        edge_seen = rising ? (now & ~was) : (~now & was);
    endfunction

    logic edge1, edge2;
    assign edge1 = edge_seen(sync1_q[1], cap1_s_q, ctrl_one_q[EBT_C1_EDGE1]); // R08
    assign edge2 = edge_seen(sync2_q[1], cap2_s_q, ctrl_two_q[EBT_C2_EDGE2]); // R14

    // Prescaler; frozen by the freeze bit
    logic [13:0] presc_top;
    always_comb begin
        unique case (ctrl_two_q[EBT_C2_CLK_HI:EBT_C2_CLK_LO])                 // R13
            EBT_CLK_DIV4: presc_top = 14'(EBT_DIV_BY4 - 1);
            EBT_CLK_DIV2: presc_top = 14'(EBT_DIV_BY2 - 1);
            EBT_CLK_DIV8: presc_top = 14'(EBT_DIV_BY8 - 1);
            EBT_CLK_SLOW: presc_top = 14'(SLOW_DIV - 1);
        endcase
    end

    logic slow_sel, tick;
    assign slow_sel = ctrl_two_q[EBT_C2_CLK_HI] & ctrl_two_q[EBT_C2_CLK_LO];
    // Slow rate counts oscillator ticks, the others count CPU cycles
    assign tick = !freeze_q && (!slow_sel || osc_tick) && (presc_q == presc_top); // R20

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            presc_q <= 14'h0000;
        end else if (!freeze_q && (!slow_sel || osc_tick)) begin             // R20
            presc_q <= (presc_q >= presc_top) ? 14'h0000 : presc_q + 14'h0001;
        end
    end

    // Access decode
    logic wr_ctrl1, wr_ctrl2, wr_flags, rd_flags, wr_cnt;
    logic acc_cap1, acc_cmp1, acc_cnt, acc_cap2, acc_cmp2;
    assign wr_ctrl1 = reg_write && reg_addr == EBT_OFF_CTRL_ONE;
    assign wr_ctrl2 = reg_write && reg_addr == EBT_OFF_CTRL_TWO;
    assign wr_flags = reg_write && reg_addr == EBT_OFF_FLAGS;
    assign rd_flags = reg_read  && reg_addr == EBT_OFF_FLAGS;
    assign wr_cnt   = reg_write && (reg_addr == EBT_OFF_COUNT
                                 || reg_addr == EBT_OFF_ALT_COUNT);
    assign acc_cap1 = (reg_read || reg_write) && reg_addr == EBT_OFF_CAP_ONE;
    assign acc_cmp1 = (reg_read || reg_write) && reg_addr == EBT_OFF_CMP_ONE;
    assign acc_cnt  = (reg_read || reg_write) && reg_addr == EBT_OFF_COUNT; // R17
    assign acc_cap2 = (reg_read || reg_write) && reg_addr == EBT_OFF_CAP_TWO;
    assign acc_cmp2 = (reg_read || reg_write) && reg_addr == EBT_OFF_CMP_TWO;

    // Events
    logic match1, match2, wrap, pulse_trig, pwm_end;
    assign match1     = tick && count_q == cmp_one_act_q;
    assign match2     = tick && count_q == cmp_two_act_q;
    assign wrap       = tick && count_q == EBT_COUNT_TOP;
    assign pulse_trig = one_pulse_mode && edge1;                            // R11
    assign pwm_end    = pwm_mode && match2;

    // Control registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_one_q <= EBT_CTRL_RESET;
            ctrl_two_q <= EBT_CTRL_RESET;
            freeze_q   <= 1'b0;
        end else begin
            if (wr_ctrl1) ctrl_one_q <= reg_wdata;
            if (wr_ctrl2) ctrl_two_q <= reg_wdata & EBT_CTRL2_MASK;        // R14
            if (wr_flags) freeze_q <= reg_wdata[EBT_F_FREEZE];             // R20
        end
    end

    // Compare registers; PWM takes new values only at period end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmp_one_q     <= 8'h00;
            cmp_two_q     <= 8'h00;
            cmp_one_act_q <= 8'h00;
            cmp_two_act_q <= 8'h00;
        end else begin
            if (reg_write && reg_addr == EBT_OFF_CMP_ONE) cmp_one_q <= reg_wdata;
            if (reg_write && reg_addr == EBT_OFF_CMP_TWO) cmp_two_q <= reg_wdata;
            if (!pwm_mode || pwm_end) begin                                // R12
                cmp_one_act_q <= cmp_one_q;
                cmp_two_act_q <= cmp_two_q;
            end
        end
    end

    // Counter: write resets, trigger or PWM end reloads, else counts
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= EBT_COUNT_RESET;
        end else if (wr_cnt || pulse_trig || pwm_end) begin                // R23
            count_q <= EBT_COUNT_RESET;
        end else if (tick) begin                                           // R20
            count_q <= count_q + 8'h01;
        end
    end

    // Capture registers; contents undefined until first capture
    always_ff @(posedge clock) begin
        if (edge1 && !pwm_mode) cap_one_q <= count_q;                      // R22
        if (edge2) cap_two_q <= count_q;
    end

    // Flags: set beats clear; clear needs an access to the flag's own register after an arming flag-register read
    logic set_cap1, set_cmp1, set_cap2, set_cmp2;
    assign set_cap1 = (edge1 && !pwm_mode) || pwm_end;                     // R15
    assign set_cmp1 = match1 && !pwm_mode && !one_pulse_mode;              // R16 R21
    assign set_cmp2 = match2 && !pwm_mode;                                 // R19 R21
    assign set_cap2 = edge2;                                               // R18

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            f_cap1_q <= 1'b0;
            f_cmp1_q <= 1'b0;
            f_ovf_q  <= 1'b0;
            f_cap2_q <= 1'b0;
            f_cmp2_q <= 1'b0;
        end else begin
            f_cap1_q <= set_cap1 | (f_cap1_q & ~(acc_cap1 & arm_cap1_q));  // R15 R24
            f_cmp1_q <= set_cmp1 | (f_cmp1_q & ~(acc_cmp1 & arm_cmp1_q));  // R16 R24
            f_ovf_q  <= wrap     | (f_ovf_q  & ~(acc_cnt  & arm_ovf_q));   // R17 R24
            f_cap2_q <= set_cap2 | (f_cap2_q & ~(acc_cap2 & arm_cap2_q));  // R18 R24
            f_cmp2_q <= set_cmp2 | (f_cmp2_q & ~(acc_cmp2 & arm_cmp2_q));  // R19 R24
        end
    end

    // Arm on a flag read while set; a new set or the clear disarms
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            arm_cap1_q <= 1'b0;
            arm_cmp1_q <= 1'b0;
            arm_ovf_q  <= 1'b0;
            arm_cap2_q <= 1'b0;
            arm_cmp2_q <= 1'b0;
        end else begin
            arm_cap1_q <= (rd_flags & f_cap1_q) | (arm_cap1_q & ~set_cap1 & ~acc_cap1); // R24
            arm_cmp1_q <= (rd_flags & f_cmp1_q) | (arm_cmp1_q & ~set_cmp1 & ~acc_cmp1); // R24
            arm_ovf_q  <= (rd_flags & f_ovf_q)  | (arm_ovf_q  & ~wrap     & ~acc_cnt);  // R24
            arm_cap2_q <= (rd_flags & f_cap2_q) | (arm_cap2_q & ~set_cap2 & ~acc_cap2); // R24
            arm_cmp2_q <= (rd_flags & f_cmp2_q) | (arm_cmp2_q & ~set_cmp2 & ~acc_cmp2); // R24
        end
    end

    // Pin levels; pulse and PWM modes use level two on pin one
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin1_q <= 1'b0;
            pin2_q <= 1'b0;
        end else begin
            if (pulse_trig || pwm_end) begin
                pin1_q <= ctrl_one_q[EBT_C1_LEVEL2];                       // R07 R11 R12
            end else if (match1 || (wr_ctrl1 && reg_wdata[EBT_C1_FORCE1])) begin
                pin1_q <= ctrl_one_q[EBT_C1_LEVEL1];                       // R06 R09
            end
            if (!one_pulse_mode && !pwm_mode
                && (match2 || (wr_ctrl1 && reg_wdata[EBT_C1_FORCE2]))) begin
                pin2_q <= ctrl_one_q[EBT_C1_LEVEL2];                       // R05 R07
            end
        end
    end

    // Pin drivers; enables hand the pin over, freeze drops it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            compare_output_one    <= 1'b0;
            compare_output_two    <= 1'b0;
            compare_output_one_en <= 1'b0;
            compare_output_two_en <= 1'b0;
        end else begin
            compare_output_one    <= pin1_q;
            compare_output_two    <= pin2_q;
            compare_output_one_en <= ctrl_two_q[EBT_C2_PIN1_EN] & ~freeze_q; // R10 R20
            compare_output_two_en <= ctrl_two_q[EBT_C2_PIN2_EN] & ~freeze_q; // R10 R20
        end
    end

    // Shared interrupt; wake from wait is left to the CPU side
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= !cpu_irq_mask && (                                // R01
                (ctrl_one_q[EBT_C1_CAP_IE] && (f_cap1_q || f_cap2_q)) ||   // R02
                (ctrl_one_q[EBT_C1_CMP_IE] && (f_cmp1_q || f_cmp2_q)) ||   // R03
                (ctrl_one_q[EBT_C1_OVF_IE] && f_ovf_q));                   // R04
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                EBT_OFF_CTRL_TWO:  reg_rdata <= ctrl_two_q;
                EBT_OFF_CTRL_ONE:  reg_rdata <= ctrl_one_q;
                EBT_OFF_FLAGS:     reg_rdata <= {f_cap1_q, f_cmp1_q, f_ovf_q, f_cap2_q,
                                                 f_cmp2_q, freeze_q, 2'b00}; // R20
                EBT_OFF_CAP_ONE:   reg_rdata <= cap_one_q;
                EBT_OFF_CMP_ONE:   reg_rdata <= cmp_one_q;
                EBT_OFF_COUNT:     reg_rdata <= count_q;
                EBT_OFF_ALT_COUNT: reg_rdata <= count_q;
                EBT_OFF_CAP_TWO:   reg_rdata <= cap_two_q;
                EBT_OFF_CMP_TWO:   reg_rdata <= cmp_two_q;
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // ebt_timer

/* verif/ebt_timer_checker.sv */
// Assertion checker for the eight-bit timer control and status block
`timescale 1ns/10ps
module ebt_timer_checker
    import ebt_pkg::*;
#(
    parameter int SLOW_DIV = 8000
) (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       osc_tick,
    input wire logic       cpu_irq_mask,
    input wire logic       capture_input_one,
    input wire logic       capture_input_two,
    input wire logic       compare_output_one,
    input wire logic       compare_output_one_en,
    input wire logic       compare_output_two,
    input wire logic       compare_output_two_en,
    input wire logic       timer_irq
);
    logic [7:0] c1_q;
    logic [7:0] c2_q;
    logic       frz_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Shadow of control writes, so pin rules can be judged from the bus alone
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            c1_q  <= 8'h00;
            c2_q  <= 8'h00;
            frz_q <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == EBT_OFF_CTRL_ONE) c1_q <= reg_wdata;
            if (reg_addr == EBT_OFF_CTRL_TWO) c2_q <= reg_wdata;
            if (reg_addr == EBT_OFF_FLAGS) frz_q <= reg_wdata[2];
        end
    end

    AST_IRQ_MASKED: assert property (cpu_irq_mask [*2] |-> !timer_irq)
        else $error("interrupt raised while masked");
    AST_IRQ_NO_ENABLE: assert property ((c1_q[7:5] == 3'b000) [*2] |-> !timer_irq)
        else $error("interrupt raised with all enables clear");
    AST_CTRL2_BIT0: assert property (reg_read && reg_addr == EBT_OFF_CTRL_TWO
        |=> reg_rdata[0] == 1'b0) else $error("reserved control bit reads one");
    AST_FLAGS_LOW: assert property (reg_read && reg_addr == EBT_OFF_FLAGS
        |=> reg_rdata[1:0] == 2'b00 && reg_rdata[2] == $past(frz_q))
        else $error("flag register low bits wrong");
    AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside read answer cycle");
    AST_FORCE_TWO: assert property (reg_write && reg_addr == EBT_OFF_CTRL_ONE && reg_wdata[4]
        && c2_q[6] && c2_q[5:4] == 2'b00 && !frz_q
        |-> ##2 compare_output_two == $past(c1_q[2], 2))
        else $error("forced pin two level wrong");
    AST_FORCE_ONE: assert property (reg_write && reg_addr == EBT_OFF_CTRL_ONE && reg_wdata[3]
        && c2_q[7] && c2_q[5:4] == 2'b00 && !frz_q
        |-> ##2 compare_output_one == $past(c1_q[0], 2)) else $error("forced pin one level wrong");
    AST_EN_FREEZE: assert property (frz_q [*3] |-> !compare_output_one_en && !compare_output_two_en)
        else $error("pin enabled while frozen");
    AST_EN_ONE: assert property ((c2_q[7] && !frz_q) [*3] |-> compare_output_one_en)
        else $error("pin one not handed to timer");
    AST_EN_TWO_OFF: assert property (!c2_q[6] [*3] |-> !compare_output_two_en)
        else $error("pin two not released");

    // Main scenarios reached
    cover property ($rose(timer_irq));
    cover property (compare_output_two_en && compare_output_two);
    cover property ($rose(compare_output_one));
endmodule // ebt_timer_checker

bind ebt_timer ebt_timer_checker #(.SLOW_DIV(SLOW_DIV)) chk_u (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .osc_tick(osc_tick),
    .cpu_irq_mask(cpu_irq_mask), .capture_input_one(capture_input_one),
    .capture_input_two(capture_input_two), .compare_output_one(compare_output_one),
    .compare_output_one_en(compare_output_one_en), .compare_output_two(compare_output_two),
    .compare_output_two_en(compare_output_two_en), .timer_irq(timer_irq));

/* verif/testbench.sv */
// Self-checking testbench for the eight-bit timer control and status block
`timescale 1ns/10ps
module testbench;
    import ebt_pkg::*;
    typedef struct { string nm; logic [7:0] e; logic [7:0] m; } ebt_note_type;
    logic clock, arst_n, reg_write, reg_read, osc_tick, cpu_irq_mask, cap1, cap2;
    logic o1, o1_en, o2, o2_en, irq, chk, pend, pin_chk;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v, sv, rnd;
    ebt_note_type note_q[$];
    ebt_note_type n;
    int fail_count, checks;

    ebt_timer #(.SLOW_DIV(4)) dut_u (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .osc_tick(osc_tick), .cpu_irq_mask(cpu_irq_mask), .capture_input_one(cap1),
        .capture_input_two(cap2), .compare_output_one(o1), .compare_output_one_en(o1_en),
        .compare_output_two(o2), .compare_output_two_en(o2_en), .timer_irq(irq));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Slow tick pattern is random so the slow divider sees uneven spacing
    always @(posedge clock) osc_tick <= ($urandom % 4) == 0;

    // Oldest note is judged when a read answer or a pin sample comes due
    always @(posedge clock) begin
        if (pend || pin_chk) begin
            n = note_q.pop_front();
            sv = pend ? reg_rdata : {3'b000, irq, o1, o1_en, o2, o2_en};
            checks++;
            if ((sv & n.m) !== (n.e & n.m)) begin
                fail_count++;
                $display("BAD %s expected %h seen %h", n.nm, n.e & n.m, sv & n.m);
            end
        end
        pend <= reg_read & chk;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic c, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        chk      <= c;
        @(posedge clock);
        reg_read <= 1'b0;
        chk      <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask
    task automatic rdc(input string s, input logic [3:0] a, input logic [7:0] e, m);
        logic [7:0] d;
        note_q.push_back('{s, e, m});
        rd(a, 1'b1, d);
    endtask
    task automatic pinc(input string s, input logic [7:0] e, m);
        @(posedge clock);
        note_q.push_back('{s, e, m});
        pin_chk <= 1'b1;
        @(posedge clock);
        pin_chk <= 1'b0;
    endtask
    // Bounded wait for one flag; a miss counts as a mismatch
    task automatic poll(input int b);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 400 && d[b] !== 1'b1; i++) rd(EBT_OFF_FLAGS, 1'b0, d);
        checks++;
        if (d[b] !== 1'b1) begin
            fail_count++;
            $display("BAD flag bit %0d expected 1 seen %b", b, d[b]);
        end
    endtask
    task automatic clear_all;
        rd(EBT_OFF_FLAGS, 1'b0, v);
        rd(EBT_OFF_CAP_ONE, 1'b0, v);
        rd(EBT_OFF_CMP_ONE, 1'b0, v);
        rd(EBT_OFF_CMP_TWO, 1'b0, v);
    endtask
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        fail_count++;
        end_sim();
    end

    initial begin
        {arst_n, reg_write, reg_read, cap1, cap2, chk, pin_chk} = '0;
        {reg_addr, reg_wdata, fail_count, checks} = '0;
        cpu_irq_mask = 1'b1;
        rnd = 8'($urandom(49));
        rnd = 8'h10 + 8'($urandom % 224);
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        rdc("ctrl two", EBT_OFF_CTRL_TWO, 8'h00, 8'hff);
        rdc("ctrl one", EBT_OFF_CTRL_ONE, 8'h00, 8'hff);
        rdc("flags", EBT_OFF_FLAGS, 8'h00, 8'hff);
        rdc("unmapped", 4'h9, 8'h00, 8'hff);
        wr(EBT_OFF_CTRL_TWO, 8'hff);
        rdc("ctrl two", EBT_OFF_CTRL_TWO, 8'hfe, 8'hff);
        wr(EBT_OFF_CTRL_TWO, 8'h04);
        // Freeze, reset the count, and see it hold still
        wr(EBT_OFF_FLAGS, 8'h04);
        rdc("freeze", EBT_OFF_FLAGS, 8'h04, 8'h07);
        wr(EBT_OFF_COUNT, 8'h00);
        repeat (10) @(posedge clock);
        rdc("count", EBT_OFF_COUNT, 8'hfc, 8'hff);
        // Overflow, masking, and the two-step clear
        wr(EBT_OFF_CTRL_ONE, 8'h20);
        wr(EBT_OFF_FLAGS, 8'h00);
        poll(EBT_F_OVF);
        pinc("irq masked", 8'h00, 8'h10);
        cpu_irq_mask <= 1'b0;
        repeat (3) @(posedge clock);
        pinc("irq ovf", 8'h10, 8'h10);
        rd(EBT_OFF_ALT_COUNT, 1'b0, v);
        rdc("ovf kept", EBT_OFF_FLAGS, 8'h20, 8'h20);
        rd(EBT_OFF_COUNT, 1'b0, v);
        rdc("ovf clear", EBT_OFF_FLAGS, 8'h00, 8'h20);
        pinc("irq off", 8'h00, 8'h10);
        // Capture one on falling edge only, while frozen at the reset count
        wr(EBT_OFF_FLAGS, 8'h04);
        wr(EBT_OFF_COUNT, 8'h00);
        wr(EBT_OFF_CTRL_ONE, 8'h80);
        clear_all();
        cap1 <= 1'b1;
        repeat (6) @(posedge clock);
        rdc("no cap", EBT_OFF_FLAGS, 8'h00, 8'h80);
        cap1 <= 1'b0;
        poll(EBT_F_CAP1);
        pinc("irq cap", 8'h10, 8'h10);
        rdc("cap one", EBT_OFF_CAP_ONE, 8'hfc, 8'hff);
        rdc("cap clear", EBT_OFF_FLAGS, 8'h00, 8'h80);
        wr(EBT_OFF_CTRL_TWO, 8'h06);
        cap2 <= 1'b1;
        poll(EBT_F_CAP2);
        rdc("cap two", EBT_OFF_CAP_TWO, 8'hfc, 8'hff);
        rdc("cap2 clear", EBT_OFF_FLAGS, 8'h00, 8'h10);
        // Compare matches drive level one and flags
        wr(EBT_OFF_CMP_ONE, 8'h02);
        wr(EBT_OFF_CMP_TWO, rnd);
        wr(EBT_OFF_CTRL_ONE, 8'h41);
        wr(EBT_OFF_CTRL_TWO, 8'h84);
        wr(EBT_OFF_FLAGS, 8'h00);
        poll(EBT_F_CMP1);
        repeat (3) @(posedge clock);
        pinc("match one", 8'h1c, 8'h1d);
        poll(EBT_F_CMP2);
        rdc("cmp two", EBT_OFF_CMP_TWO, rnd, 8'hff);
        rdc("cmp2 clear", EBT_OFF_FLAGS, 8'h00, 8'h08);
        // Forced levels with no match
        wr(EBT_OFF_CTRL_TWO, 8'h44);
        wr(EBT_OFF_CTRL_ONE, 8'h04);
        wr(EBT_OFF_CTRL_ONE, 8'h14);
        repeat (3) @(posedge clock);
        // Pin one keeps the level of its last match; a level write alone moves nothing
        pinc("force two", 8'h0b, 8'h0f);
        wr(EBT_OFF_CTRL_TWO, 8'h84);
        wr(EBT_OFF_CTRL_ONE, 8'h00);
        wr(EBT_OFF_CTRL_ONE, 8'h08);
        repeat (3) @(posedge clock);
        pinc("force one", 8'h04, 8'h0d);
        // Waveform mode: period end sets capture flag one, compare flags stay clear
        wr(EBT_OFF_CTRL_TWO, 8'h94);
        clear_all();
        repeat (1200) @(posedge clock);
        rdc("pwm flags", EBT_OFF_FLAGS, 8'h80, 8'hc8);
        // Single pulse: rising edge on capture one starts it, compare one ends it
        wr(EBT_OFF_CTRL_TWO, 8'ha4);
        wr(EBT_OFF_CTRL_ONE, 8'h06);
        wr(EBT_OFF_CMP_ONE, 8'h10);
        clear_all();
        rdc("pulse idle", EBT_OFF_FLAGS, 8'h00, 8'h80);
        cap1 <= 1'b1;
        repeat (6) @(posedge clock);
        pinc("pulse on", 8'h0c, 8'h0c);
        repeat (60) @(posedge clock);
        pinc("pulse off", 8'h04, 8'h0c);
        rdc("pulse flags", EBT_OFF_FLAGS, 8'h80, 8'hc0);
        end_sim();
    end
endmodule // testbench
